// file: nv_port_pkg.sv
// Constants shared by both ends of the nonvolatile data access port.
// Assumes a single 125 MHz pclk domain; write timing is taken from a divided tick.
package nv_port_pkg;

   // Storage geometry.
   localparam int unsigned NV_ADDR_W      = 9;
   localparam int unsigned NV_DATA_W      = 8;
   localparam int unsigned NV_BYTES_SMALL = 256;
   localparam int unsigned NV_BYTES_LARGE = 512;
   localparam int unsigned ADDR_TOP_BIT   = 8;

   // I/O register selects as seen by the processor core.
   typedef logic [1:0] io_sel_t;
   localparam io_sel_t IO_CTRL      = 2'h0;
   localparam io_sel_t IO_DATA      = 2'h1;
   localparam io_sel_t IO_ADDR_LOW  = 2'h2;
   localparam io_sel_t IO_ADDR_HIGH = 2'h3;

   // Control register field positions, mode reset value and erased byte value.
   localparam int unsigned CTRL_READ_BIT = 0;
   localparam int unsigned CTRL_BUSY_BIT = 1;
   localparam int unsigned CTRL_ARM_BIT  = 2;
   localparam int unsigned CTRL_MODE_LSB = 4;
   localparam int unsigned CTRL_MODE_MSB = 5;
   localparam logic [1:0]  MODE_RESET    = 2'h0;
   localparam logic [7:0]  DATA_ERASED   = 8'hff;

   // Programming modes.
   localparam logic [1:0] MODE_ATOMIC     = 2'h0;
   localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
   localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;

   // Cycle counts of the core clock.
   localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
   localparam logic [2:0] READ_HALT_CYCLES  = 3'h4;
   localparam logic [2:0] WRITE_HALT_CYCLES = 3'h2;

   // Write timing: oscillator ticks per write and the tick rate derived from pclk.
   localparam int unsigned CLK_MHZ         = 125;
   localparam int unsigned WRITE_TIME_US   = 3300;
   localparam int unsigned SPLIT_TIME_US   = 1800;
   localparam int unsigned WRITE_OSC_TICKS = 26368;
   localparam int unsigned TICK_DIV        = (WRITE_TIME_US * CLK_MHZ) / WRITE_OSC_TICKS;
   localparam int unsigned TICK_W          = 16;

   // APB register map of the controller end.
   localparam int unsigned APB_ADDR_W  = 12;
   localparam logic [11:0] APB_CTRL    = 12'h000;
   localparam logic [11:0] APB_DATA    = 12'h004;
   localparam logic [11:0] APB_ADDR_LO = 12'h008;
   localparam logic [11:0] APB_ADDR_HI = 12'h00c;
   localparam logic [11:0] APB_STATUS  = 12'h010;
   localparam int unsigned STAT_HALT_BIT = 0;
   localparam int unsigned STAT_ERR_BIT  = 1;

endpackage

// file: nv_port_if.sv
// Interface between the processor core end and the nonvolatile access port.
// Assumes both ends run on the same pclk; strobes are one-cycle pulses.
`timescale 1ns/10ps
interface nv_port_if;
   import nv_port_pkg::*;

   logic          io_wr;
   logic          io_rd;
   io_sel_t       io_sel;
   logic [7:0]    io_wdata;
   logic [7:0]    io_rdata;
   logic          cpu_halt;

   modport device (
      input  io_wr,
      input  io_rd,
      input  io_sel,
      input  io_wdata,
      output io_rdata,
      output cpu_halt
   );

   modport cpu (
      output io_wr,
      output io_rd,
      output io_sel,
      output io_wdata,
      input  io_rdata,
      input  cpu_halt
   );
endinterface // nv_port_if

// file: nv_write_timer.sv
// Self-timed write duration counter with its own oscillator tick divider.
// Assumes start is a one-cycle pulse that never arrives while busy is high.
`timescale 1ns/10ps
module nv_write_timer
   import nv_port_pkg::*;
#(
   parameter int unsigned DIV = nv_port_pkg::TICK_DIV
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Control
   input  wire logic              start,
   input  wire logic [TICK_W-1:0] ticks,
   // Status
   output logic                   busy,
   output logic                   done
);
   import nv_port_pkg::*;

   localparam logic [TICK_W-1:0] DIV_LAST = TICK_W'(DIV - 1);

   logic [TICK_W-1:0] div_q, div_d;
   logic [TICK_W-1:0] cnt_q, cnt_d;
   logic              busy_q, busy_d;
   logic              done_q, done_d;
   logic              tick;

   always_comb begin
      tick   = (div_q == '0);
      div_d  = tick ? DIV_LAST : div_q - 1'b1;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (start) begin
         cnt_d  = (ticks == '0) ? TICK_W'(1) : ticks;
         busy_d = 1'b1;
      end else if (busy_q && tick) begin
         cnt_d = cnt_q - 1'b1;
         if (cnt_q == TICK_W'(1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
endmodule // nv_write_timer

// file: nv_port_device.sv
// Nonvolatile data access port: address, data and control registers in the core's
// I/O space, a byte-wide storage array, a guarded self-timed write and core halts.
// Assumes the core issues no access while cpu_halt is high and keeps rules of its own.
`timescale 1ns/10ps
module nv_port_device
   import nv_port_pkg::*;
#(
   parameter bit          SMALL_VARIANT = 1'b0,
   parameter int unsigned WRITE_TICKS   = nv_port_pkg::WRITE_OSC_TICKS,
   parameter int unsigned DIV           = nv_port_pkg::TICK_DIV
) (
   // Clock and reset
   input  wire logic   pclk,
   input  wire logic   presetn,
   // Core side
   nv_port_if.device   bus,
   // User side status
   output logic        nv_write_busy
);
   import nv_port_pkg::*;

   localparam int unsigned NV_BYTES    = SMALL_VARIANT ? NV_BYTES_SMALL : NV_BYTES_LARGE;
   localparam logic [TICK_W-1:0] TICKS_FULL  = TICK_W'(WRITE_TICKS);
   localparam logic [TICK_W-1:0] TICKS_SPLIT = TICK_W'((WRITE_TICKS * SPLIT_TIME_US) / WRITE_TIME_US);

   // Index into the array; the top address bit is ignored on the small variant.
   function automatic logic [NV_ADDR_W-1:0] nv_index(input logic [NV_ADDR_W-1:0] a);
      nv_index = SMALL_VARIANT ? {1'b0, a[ADDR_TOP_BIT-1:0]} : a;
   endfunction

   logic [NV_DATA_W-1:0] nv_mem [NV_BYTES];

   logic [NV_ADDR_W-1:0] nv_address_q, nv_address_d;
   logic [NV_DATA_W-1:0] nv_data_byte_q, nv_data_byte_d;
   logic [NV_ADDR_W-1:0] pend_addr_q, pend_addr_d;
   logic [NV_DATA_W-1:0] pend_data_q, pend_data_d;
   logic [1:0]           pend_mode_q, pend_mode_d;

   logic [1:0]           prog_mode_q, prog_mode_d;
   logic                 master_write_arm_q, master_write_arm_d;
   logic [2:0]           arm_cnt_q, arm_cnt_d;
   logic [2:0]           halt_cnt_q, halt_cnt_d;
   logic                 halt_q, halt_d;
   logic [7:0]           io_rdata_q, io_rdata_d;

   logic                 write_strobe_busy;
   logic                 write_done;
   logic                 write_start;
   logic [TICK_W-1:0]    write_ticks;
   logic                 ctrl_wr;
   logic [7:0]           ctrl_view;
   logic [7:0]           mem_rd_byte;
   logic [7:0]           old_byte;

   nv_write_timer #(
      .DIV     (DIV)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (write_start),
      .ticks   (write_ticks),
      .busy    (write_strobe_busy),
      .done    (write_done)
   );

   assign mem_rd_byte = nv_mem[nv_index(nv_address_q)];
   assign old_byte    = nv_mem[pend_addr_q];

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[CTRL_MODE_MSB:CTRL_MODE_LSB] = prog_mode_q;
      ctrl_view[CTRL_ARM_BIT]  = master_write_arm_q;
      ctrl_view[CTRL_BUSY_BIT] = write_strobe_busy;
   end

   always_comb begin
      nv_address_d       = nv_address_q;
      nv_data_byte_d     = nv_data_byte_q;
      pend_addr_d        = pend_addr_q;
      pend_data_d        = pend_data_q;
      pend_mode_d        = pend_mode_q;
      prog_mode_d        = prog_mode_q;
      master_write_arm_d = master_write_arm_q;
      arm_cnt_d          = arm_cnt_q;
      halt_cnt_d         = (halt_cnt_q != 3'h0) ? halt_cnt_q - 1'b1 : 3'h0;
      io_rdata_d         = io_rdata_q;
      write_start        = 1'b0;
      write_ticks        = TICKS_FULL;
      ctrl_wr            = bus.io_wr && (bus.io_sel == IO_CTRL);

      // The arm window closes by itself four cycles after it was opened.
      if (arm_cnt_q != 3'h0) begin
         arm_cnt_d = arm_cnt_q - 1'b1;
         if (arm_cnt_q == 3'h1) begin
            master_write_arm_d = 1'b0;
         end
      end

      if (bus.io_wr) begin
         unique case (bus.io_sel)
            IO_CTRL: begin
               if (!write_strobe_busy) begin
                  prog_mode_d = bus.io_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB];
               end
               if (bus.io_wdata[CTRL_ARM_BIT]) begin
                  master_write_arm_d = 1'b1;
                  arm_cnt_d          = ARM_WINDOW_CYCLES;
               end
            end
            IO_DATA: begin
               nv_data_byte_d = bus.io_wdata;
            end
            IO_ADDR_LOW: begin
               if (!write_strobe_busy) begin
                  nv_address_d[ADDR_TOP_BIT-1:0] = bus.io_wdata;
               end
            end
            IO_ADDR_HIGH: begin
               if (!write_strobe_busy) begin
                  nv_address_d[ADDR_TOP_BIT] = bus.io_wdata[0];
               end
            end
         endcase
      end

      // Guarded write start: strobe only counts while the arm window is open.
      if (ctrl_wr && bus.io_wdata[CTRL_BUSY_BIT] && master_write_arm_q && !write_strobe_busy) begin
         write_start        = 1'b1;
         master_write_arm_d = 1'b0;
         arm_cnt_d          = 3'h0;
         pend_addr_d        = nv_index(nv_address_q);
         pend_data_d        = nv_data_byte_q;
         pend_mode_d        = prog_mode_q;
         halt_cnt_d         = WRITE_HALT_CYCLES;
         write_ticks        = (prog_mode_q == MODE_ATOMIC) ? TICKS_FULL : TICKS_SPLIT;
      end else if (ctrl_wr && bus.io_wdata[CTRL_READ_BIT] && !write_strobe_busy) begin
         nv_data_byte_d = mem_rd_byte;
         halt_cnt_d     = READ_HALT_CYCLES;
      end

      halt_d = (halt_cnt_d != 3'h0);

      if (bus.io_rd) begin
         unique case (bus.io_sel)
            IO_CTRL:      io_rdata_d = ctrl_view;
            IO_DATA:      io_rdata_d = nv_data_byte_q;
            IO_ADDR_LOW:  io_rdata_d = nv_address_q[ADDR_TOP_BIT-1:0];
            IO_ADDR_HIGH: io_rdata_d = {7'h00, nv_address_q[ADDR_TOP_BIT]};
         endcase
      end
   end

   // Control state, reset with the core.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_mode_q        <= MODE_RESET;
         master_write_arm_q <= 1'b0;
         arm_cnt_q          <= 3'h0;
         halt_cnt_q         <= 3'h0;
         halt_q             <= 1'b0;
         io_rdata_q         <= 8'h00;
      end else begin
         prog_mode_q        <= prog_mode_d;
         master_write_arm_q <= master_write_arm_d;
         arm_cnt_q          <= arm_cnt_d;
         halt_cnt_q         <= halt_cnt_d;
         halt_q             <= halt_d;
         io_rdata_q         <= io_rdata_d;
      end
   end

   // Address and data contents are left as they are by reset.
   always_ff @(posedge pclk) begin
      nv_address_q   <= nv_address_d;
      nv_data_byte_q <= nv_data_byte_d;
      pend_addr_q    <= pend_addr_d;
      pend_data_q    <= pend_data_d;
      pend_mode_q    <= pend_mode_d;
   end

   // The array changes only when a guarded write has run its timed length, full or split.
   always_ff @(posedge pclk) begin
      if (write_done) begin
         unique case (pend_mode_q)
            MODE_ATOMIC:     nv_mem[pend_addr_q] <= pend_data_q;
            MODE_ERASE_ONLY: nv_mem[pend_addr_q] <= DATA_ERASED;
            MODE_WRITE_ONLY: nv_mem[pend_addr_q] <= old_byte & pend_data_q;
            default:         nv_mem[pend_addr_q] <= old_byte;
         endcase
      end
   end

   assign bus.io_rdata  = io_rdata_q;
   assign bus.cpu_halt  = halt_q;
   assign nv_write_busy = write_strobe_busy;
endmodule // nv_port_device

// file: nv_port_cpu.sv
// Core-side end: an APB slave whose first four registers stand for the port's I/O registers
// and replay each APB access to them as one core I/O access, honouring the core halt.
// Assumes the device end answers io_rd one cycle later and raises cpu_halt one cycle after a strobe.
`timescale 1ns/10ps
module nv_port_cpu
   import nv_port_pkg::*;
(
   // Clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // APB slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [nv_port_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                       pwdata,
   output logic [31:0]                            prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Port side
   nv_port_if.cpu                                 bus
);
   import nv_port_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_SETTLE, H_DONE} host_state_t;

   host_state_t state_q, state_d;
   logic        io_wr_q, io_wr_d;
   logic        io_rd_q, io_rd_d;
   io_sel_t     io_sel_q, io_sel_d;
   logic [7:0]  io_wdata_q, io_wdata_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic        err_q, err_d;
   logic        mapped;
   io_sel_t     sel;

   always_comb begin
      mapped = 1'b1;
      sel    = IO_CTRL;
      unique case (paddr)
         APB_CTRL:    sel = IO_CTRL;
         APB_DATA:    sel = IO_DATA;
         APB_ADDR_LO: sel = IO_ADDR_LOW;
         APB_ADDR_HI: sel = IO_ADDR_HIGH;
         default:     mapped = 1'b0;
      endcase
   end

   always_comb begin
      state_d    = state_q;
      io_wr_d    = 1'b0;
      io_rd_d    = 1'b0;
      io_sel_d   = io_sel_q;
      io_wdata_d = io_wdata_q;
      prdata_d   = prdata_q;
      pready_d   = 1'b0;
      pslverr_d  = 1'b0;
      err_d      = err_q;
      unique case (state_q)
         H_IDLE: begin
            // Core accesses launch in the setup phase so that an arm write and the strobe after it
            // reach the port inside its four-cycle window.
            if (psel && mapped && !bus.cpu_halt) begin
               io_wr_d    = pwrite;
               io_rd_d    = !pwrite;
               io_sel_d   = sel;
               io_wdata_d = pwdata[7:0];
               state_d    = H_ISSUE;
            end else if (psel && penable && (paddr == APB_STATUS)) begin
               prdata_d = 32'h0000_0000;
               prdata_d[STAT_HALT_BIT] = bus.cpu_halt;
               prdata_d[STAT_ERR_BIT]  = err_q;
               if (pwrite && pwdata[STAT_ERR_BIT]) begin
                  err_d = 1'b0;
               end
               pready_d = 1'b1;
               state_d  = H_DONE;
            end else if (psel && penable && !mapped) begin
               prdata_d  = 32'h0000_0000;
               pready_d  = 1'b1;
               pslverr_d = 1'b1;
               err_d     = 1'b1;
               state_d   = H_DONE;
            end
         end
         H_ISSUE: begin
            // Writes answer at once; a halt they raise holds back the next access instead.
            if (io_wr_q) begin
               pready_d = 1'b1;
               state_d  = H_DONE;
            end else begin
               state_d = H_SETTLE;
            end
         end
         H_SETTLE: begin
            if (!bus.cpu_halt) begin
               prdata_d = {24'h00_0000, bus.io_rdata};
               pready_d = 1'b1;
               state_d  = H_DONE;
            end
         end
         H_DONE: begin
            state_d = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= H_IDLE;
         io_wr_q    <= 1'b0;
         io_rd_q    <= 1'b0;
         io_sel_q   <= IO_CTRL;
         io_wdata_q <= 8'h00;
         prdata_q   <= 32'h0000_0000;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
         err_q      <= 1'b0;
      end else begin
         state_q    <= state_d;
         io_wr_q    <= io_wr_d;
         io_rd_q    <= io_rd_d;
         io_sel_q   <= io_sel_d;
         io_wdata_q <= io_wdata_d;
         prdata_q   <= prdata_d;
         pready_q   <= pready_d;
         pslverr_q  <= pslverr_d;
         err_q      <= err_d;
      end
   end

   assign bus.io_wr    = io_wr_q;
   assign bus.io_rd    = io_rd_q;
   assign bus.io_sel   = io_sel_q;
   assign bus.io_wdata = io_wdata_q;
   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
endmodule // nv_port_cpu

// file: nv_port_properties.sv
// Concurrent checks on the core I/O link between the two ends of the access port.
// Assumes one pclk domain, presetn asynchronous active low; split-mode writes run the shortened time.
`timescale 1ns/10ps
module nv_port_properties #(
   parameter int unsigned WRITE_TICKS = 16,
   parameter int unsigned DIV         = 4
) (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // Core I/O link
   input wire logic                 io_wr,
   input wire logic                 io_rd,
   input wire nv_port_pkg::io_sel_t io_sel,
   input wire logic [7:0]           io_wdata,
   input wire logic [7:0]           io_rdata,
   input wire logic                 cpu_halt,
   // Write status
   input wire logic                 nv_write_busy
);
   import nv_port_pkg::*;

   localparam int unsigned BUSY_MIN = (WRITE_TICKS - 1) * DIV;
   localparam int unsigned BUSY_MAX = (WRITE_TICKS + 1) * DIV;
   localparam int unsigned SPLIT_T   = (WRITE_TICKS * SPLIT_TIME_US) / WRITE_TIME_US;
   localparam int unsigned SPLIT_MIN = (SPLIT_T - 1) * DIV;
   localparam int unsigned SPLIT_MAX = (SPLIT_T + 1) * DIV;

   logic        ctrl_wr;
   logic [2:0]  arm_left_q;
   logic [2:0]  arm_left_d;
   logic [15:0] busy_len_q;
   logic [15:0] busy_len_d;
   logic [1:0]  mode_q;
   logic [1:0]  mode_d;
   logic        split_q;
   logic        split_d;

   assign ctrl_wr = io_wr && (io_sel == IO_CTRL);

   // Tracks the open arm window and how long the current write has been timing.
   always_comb begin
      arm_left_d = (arm_left_q != 3'h0) ? arm_left_q - 3'h1 : 3'h0;
      mode_d     = mode_q;
      split_d    = split_q;
      if (ctrl_wr && !nv_write_busy) begin
         mode_d = io_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB];
      end
      if (ctrl_wr && io_wdata[CTRL_BUSY_BIT] && (arm_left_q != 3'h0) && !nv_write_busy) begin
         arm_left_d = 3'h0;
         split_d    = (mode_q != MODE_ATOMIC);
      end else if (ctrl_wr && io_wdata[CTRL_ARM_BIT]) begin
         arm_left_d = ARM_WINDOW_CYCLES;
      end
      busy_len_d = nv_write_busy ? busy_len_q + 16'h0001 : 16'h0000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_left_q <= 3'h0;
         busy_len_q <= 16'h0000;
         mode_q     <= MODE_RESET;
         split_q    <= 1'b0;
      end else begin
         arm_left_q <= arm_left_d;
         busy_len_q <= busy_len_d;
         mode_q     <= mode_d;
         split_q    <= split_d;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_read_halt: assert property (
      ctrl_wr && io_wdata[CTRL_READ_BIT] && !io_wdata[CTRL_BUSY_BIT] && !nv_write_busy
      |=> cpu_halt [*4] ##1 !cpu_halt) else $error("read halt is not four cycles");
   chk_write_halt: assert property (
      $rose(nv_write_busy) |-> cpu_halt ##1 cpu_halt ##1 !cpu_halt) else $error("write halt is not two cycles");
   chk_start_cause: assert property (
      $rose(nv_write_busy) |-> $past(ctrl_wr && io_wdata[CTRL_BUSY_BIT] && arm_left_q != 3'h0))
      else $error("write started without an armed strobe");
   chk_arm_window: assert property (
      ctrl_wr && io_wdata[CTRL_BUSY_BIT] && arm_left_q != 3'h0 && !nv_write_busy |=> nv_write_busy)
      else $error("armed strobe did not start a write");
   chk_busy_length: assert property (
      $fell(nv_write_busy) |-> split_q ? (busy_len_q >= SPLIT_MIN && busy_len_q <= SPLIT_MAX)
                                       : (busy_len_q >= BUSY_MIN && busy_len_q <= BUSY_MAX))
      else $error("write time out of range");
   chk_busy_bound: assert property (
      nv_write_busy |-> busy_len_q <= BUSY_MAX) else $error("busy held too long");
   chk_read_refused: assert property (
      ctrl_wr && io_wdata[CTRL_READ_BIT] && nv_write_busy |=> !cpu_halt [*4])
      else $error("read accepted while busy");
   chk_rdata_hold: assert property (
      !io_rd |=> $stable(io_rdata)) else $error("read byte changed without a read");
   chk_halt_cause: assert property (
      $rose(cpu_halt) |-> $past(ctrl_wr)) else $error("halt without a control write");
   chk_quiet_halt: assert property (
      cpu_halt |-> !io_wr && !io_rd) else $error("core access during halt");

   cover property (ctrl_wr && io_wdata[CTRL_READ_BIT] && !nv_write_busy);
   cover property ($rose(nv_write_busy));
   cover property (ctrl_wr && io_wdata[CTRL_READ_BIT] && nv_write_busy);
   cover property (ctrl_wr && io_wdata[CTRL_BUSY_BIT] && arm_left_q == 3'h0);
endmodule // nv_port_properties

// file: eeprom_data_access_port_tb.sv
// Self-checking bench: APB master into the core end, both port ends joined by the link.
// Assumes the write timer is shortened to WT ticks of DV pclk cycles each.
`timescale 1ns/10ps
module eeprom_data_access_port_tb;
   import nv_port_pkg::*;

   localparam int unsigned WT = 16;
   localparam int unsigned DV = 4;
   localparam bit          SV = 1'b0;

   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        nv_write_busy;
   logic [31:0] rv;
   logic        ev;
   int          miscompares;
   int          n_checks;
   int          seed;
   int          i;
   int          a;
   int          d;
   int          mem [int];

   nv_port_if link ();

   nv_port_cpu i_nv_port_cpu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
   nv_port_device #(.SMALL_VARIANT(SV), .WRITE_TICKS(WT), .DIV(DV)) i_nv_port_device (.pclk(pclk),
      .presetn(presetn), .bus(link), .nv_write_busy(nv_write_busy));
   nv_port_properties #(.WRITE_TICKS(WT), .DIV(DV)) i_nv_port_properties (.pclk(pclk), .presetn(presetn),
      .io_wr(link.io_wr), .io_rd(link.io_rd), .io_sel(link.io_sel), .io_wdata(link.io_wdata),
      .io_rdata(link.io_rdata), .cpu_halt(link.cpu_halt), .nv_write_busy(nv_write_busy));

   always #4 pclk = ~pclk;

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One APB transfer; read data and error are taken at the edge that samples pready.
   task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= adr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 300);
      if (n >= 300) miscompares++;
      rv = prdata;
      ev = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_addr(input int ad);
      apb(1'b1, APB_ADDR_LO, {24'h00_0000, ad[7:0]});
      apb(1'b1, APB_ADDR_HI, {31'h0000_0000, ad[8] & ~SV});
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, APB_CTRL, 32'h0000_0000);
         n++;
      end while (rv[CTRL_BUSY_BIT] !== 1'b0 && n < 100);
      check("control when idle", 32'h0000_0000, rv);
   endtask

   task automatic nv_write(input int ad, input int dv);
      set_addr(ad);
      apb(1'b1, APB_DATA, {24'h00_0000, dv[7:0]});
      apb(1'b1, APB_CTRL, 32'h0000_0004);
      apb(1'b1, APB_CTRL, 32'h0000_0002);
      mem[ad] = dv & 255;
      apb(1'b0, APB_CTRL, 32'h0000_0000);
      check("busy after start", 32'h0000_0002, rv & 32'h0000_0002);
   endtask

   task automatic nv_read(input int ad);
      set_addr(ad);
      apb(1'b1, APB_CTRL, 32'h0000_0001);
      apb(1'b0, APB_DATA, 32'h0000_0000);
      check("read byte", mem[ad], rv);
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      miscompares++;
      give_verdict();
   end

   initial begin
      seed = 15;
      miscompares = 0;
      n_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, APB_CTRL, 32'h0000_0000);
      check("control after reset", 32'h0000_0000, rv);
      apb(1'b1, APB_ADDR_HI, 32'hffff_ffff);
      apb(1'b0, APB_ADDR_HI, 32'h0000_0000);
      check("address high", 32'h0000_0001, rv);
      apb(1'b1, APB_ADDR_LO, 32'hffff_ffa5);
      apb(1'b0, APB_ADDR_LO, 32'h0000_0000);
      check("address low", 32'h0000_00a5, rv);
      apb(1'b1, 12'h014, 32'h0000_0001);
      check("unmapped error", 32'h0000_0001, {31'h0000_0000, ev});
      apb(1'b0, APB_STATUS, 32'h0000_0000);
      check("status error", 32'h0000_0002, rv);
      apb(1'b1, APB_STATUS, 32'h0000_0002);
      apb(1'b0, APB_STATUS, 32'h0000_0000);
      check("status cleared", 32'h0000_0000, rv);
      // Boundary addresses first, then random ones.
      for (i = 0; i < 12; i++) begin
         a = (i == 0) ? 0 : (i == 1) ? 511 : (i == 2) ? 255 : (i == 3) ? 256 : ($random(seed) & 511);
         d = $random(seed) & 255;
         nv_write(a, d);
         wait_idle();
         nv_read(a);
      end
      foreach (mem[k]) nv_read(k);
      // Strobe alone, arm with strobe together, and strobe after the window closed.
      for (i = 0; i < 3; i++) begin
         set_addr(256);
         d = (~mem[256]) & 255;
         apb(1'b1, APB_DATA, d);
         if (i == 2) begin
            apb(1'b1, APB_CTRL, 32'h0000_0004);
            repeat (6) @(posedge pclk);
         end
         apb(1'b1, APB_CTRL, (i == 1) ? 32'h0000_0006 : 32'h0000_0002);
         apb(1'b0, APB_CTRL, 32'h0000_0000);
         // A combined arm and strobe leaves the window open on its fourth cycle, when this read lands.
         check("refused strobe", (i == 1) ? 32'h0000_0004 : 32'h0000_0000, rv);
         nv_read(256);
      end
      // While a write is timing, address changes and reads are ignored.
      d = $random(seed) & 255;
      nv_write(300, d);
      apb(1'b1, APB_ADDR_LO, 32'h0000_0000);
      apb(1'b1, APB_CTRL, 32'h0000_0001);
      apb(1'b0, APB_DATA, 32'h0000_0000);
      check("data during busy", d, rv);
      wait_idle();
      apb(1'b0, APB_ADDR_LO, 32'h0000_0000);
      check("address kept", 32'h0000_002c, rv);
      nv_read(300);
      // Erase-only, write-only and reserved programming modes, chosen with the arm write.
      for (i = 1; i < 4; i++) begin
         set_addr(300);
         d = $random(seed) & 255;
         apb(1'b1, APB_DATA, d);
         apb(1'b1, APB_CTRL, (i << 4) | 4);
         apb(1'b1, APB_CTRL, 32'h0000_0002);
         mem[300] = (i == 1) ? 255 : (i == 2) ? (mem[300] & d) : mem[300];
         wait_idle();
         nv_read(300);
      end
      give_verdict();
   end
endmodule // eeprom_data_access_port_tb
